// ==== design/field_io_pkg.sv ====
// Package: register map, field layout, reset values and timing counts of the field port
`default_nettype none
package field_io_pkg;
	localparam int          CLK_FREQ_HZ      = 100_000_000;
	localparam int          HOLDOFF_MS       = 100;
	localparam int          HOLDOFF_CYCLES   = (CLK_FREQ_HZ / 1000) * HOLDOFF_MS;
	localparam int          GROUP_WIDTH      = 8;
	localparam int          IO_WIDTH         = 16;
	// Register byte offsets
	localparam logic [11:0] OUT_STATE_OFFSET = 12'h000;
	localparam logic [11:0] IN_STATE_OFFSET  = 12'h004;
	localparam logic [11:0] EDGE_CFG_OFFSET  = 12'h008;
	localparam logic [11:0] IRQ_STAT_OFFSET  = 12'h00c;
	localparam logic [11:0] IRQ_MASK_OFFSET  = 12'h010;
	localparam logic [11:0] PORT_STAT_OFFSET = 12'h014;
	// Edge configuration fields
	localparam int          EDGE_A_EN_BIT    = 0;
	localparam int          EDGE_A_FALL_BIT  = 1;
	localparam int          EDGE_B_EN_BIT    = 2;
	localparam int          EDGE_B_FALL_BIT  = 3;
	// Interrupt status fields
	localparam int          IRQ_EDGE_A_BIT   = 0;
	localparam int          IRQ_EDGE_B_BIT   = 1;
	localparam int          IRQ_SHORT_A_BIT  = 2;
	localparam int          IRQ_SHORT_B_BIT  = 3;
	localparam int          IRQ_WIDTH        = 4;
	// Port status fields
	localparam int          HOLD_A_BIT       = 0;
	localparam int          HOLD_B_BIT       = 1;
	localparam int          SCAN_LOSS_BIT    = 2;
	// Reset values
	localparam logic [15:0] OUT_STATE_RESET  = 16'h0000;
	localparam logic [3:0]  EDGE_CFG_RESET   = 4'h0;
	localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;
endpackage
`default_nettype wire

// ==== design/grouped_field_io_port.sv ====
// Field port: sixteen switched outputs, sixteen inputs, short hold-off, edge interrupts, APB registers
//
// The register addresses and the APB slave port were left to the implementer.
`default_nettype none
module grouped_field_io_port
	import field_io_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLDOFF_CYCLES
)(
	input  wire logic        pclk,          // System clock
	input  wire logic        presetn,       // Asynchronous reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB enable
	input  wire logic        pwrite,        // APB write
	input  wire logic [11:0] paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	input  wire logic [15:0] field_in,      // Field inputs, bit 0 input 1
	input  wire logic [1:0]  short_sense,   // Short sense per group, bit 0 group A
	input  wire logic        scan_loss,     // Scan loss condition
	output logic      [15:0] switched_out,  // Switched outputs, bit 0 first output
	output logic             irq            // Level interrupt
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [15:0] in_s1_ff, in_s2_ff, in_s3_ff, in_ff;
	logic [1:0]  sh_s1_ff, sh_s2_ff, sh_s3_ff, sh_ff;
	logic        sl_s1_ff, sl_s2_ff, sl_s3_ff, sl_ff;
	logic [15:0] nxt_in;
	logic [1:0]  nxt_sh;
	logic        nxt_sl;

	always_comb
	begin
		// A change counts once the second and third stages agree
		nxt_in = (in_s2_ff & in_s3_ff) | (in_ff & (in_s2_ff | in_s3_ff));
		nxt_sh = (sh_s2_ff & sh_s3_ff) | (sh_ff & (sh_s2_ff | sh_s3_ff));
		nxt_sl = (sl_s2_ff & sl_s3_ff) | (sl_ff & (sl_s2_ff | sl_s3_ff));
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_s1_ff <= 16'h0000;
			in_s2_ff <= 16'h0000;
			in_s3_ff <= 16'h0000;
			in_ff    <= 16'h0000;
			sh_s1_ff <= 2'h0;
			sh_s2_ff <= 2'h0;
			sh_s3_ff <= 2'h0;
			sh_ff    <= 2'h0;
			sl_s1_ff <= 1'b1;
			sl_s2_ff <= 1'b1;
			sl_s3_ff <= 1'b1;
			sl_ff    <= 1'b1;
		end
		else
		begin
			in_s1_ff <= field_in;
			in_s2_ff <= in_s1_ff;
			in_s3_ff <= in_s2_ff;
			in_ff    <= nxt_in;
			sh_s1_ff <= short_sense;
			sh_s2_ff <= sh_s1_ff;
			sh_s3_ff <= sh_s2_ff;
			sh_ff    <= nxt_sh;
			sl_s1_ff <= scan_loss;
			sl_s2_ff <= sl_s1_ff;
			sl_s3_ff <= sl_s2_ff;
			sl_ff    <= nxt_sl;
		end
	end

	// ****************************************
	// Short-circuit hold-off timers
	// ****************************************
	logic [31:0] hold_cnt_ff [2];
	logic [31:0] nxt_hold_cnt [2];
	logic [1:0]  hold_ff, nxt_hold;
	logic [1:0]  short_rise;

	always_comb
	begin
		for (int g = 0; g < 2; g++)
		begin
			nxt_hold[g]     = hold_ff[g];
			nxt_hold_cnt[g] = hold_cnt_ff[g];
			if (sh_ff[g])
			begin
				nxt_hold[g]     = 1'b1;
				nxt_hold_cnt[g] = 32'(HOLD_CYCLES - 1);
			end
			else if (hold_ff[g])
			begin
				if (hold_cnt_ff[g] == 32'h0)
					nxt_hold[g] = 1'b0;
				else
					nxt_hold_cnt[g] = hold_cnt_ff[g] - 32'h1;
			end
		end
		short_rise = sh_ff & ~hold_ff;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_ff        <= 2'h0;
			hold_cnt_ff[0] <= 32'h0;
			hold_cnt_ff[1] <= 32'h0;
		end
		else
		begin
			hold_ff        <= nxt_hold;
			hold_cnt_ff[0] <= nxt_hold_cnt[0];
			hold_cnt_ff[1] <= nxt_hold_cnt[1];
		end
	end

	// ****************************************
	// Registers, edge detect, outputs
	// ****************************************
	logic [15:0] out_state_ff, nxt_out_state;
	logic [3:0]  edge_cfg_ff, nxt_edge_cfg;
	logic [3:0]  irq_stat_ff, nxt_irq_stat;
	logic [3:0]  irq_mask_ff, nxt_irq_mask;
	logic [1:0]  edge_prev_ff, nxt_edge_prev;
	logic [15:0] nxt_switched_out;
	logic [31:0] nxt_prdata;
	logic        nxt_pready, nxt_pslverr, nxt_irq;
	logic        wr_en, rd_en, hit;
	logic [3:0]  events;
	logic [1:0]  edge_now;

	always_comb
	begin
		wr_en     = psel & penable & pwrite & pready;
		rd_en     = psel & ~penable;
		edge_now  = {in_ff[8], in_ff[0]};
		events    = 4'h0;
		events[IRQ_EDGE_A_BIT]  = edge_cfg_ff[EDGE_A_EN_BIT] & (edge_cfg_ff[EDGE_A_FALL_BIT] ?
			(edge_prev_ff[0] & ~edge_now[0]) : (~edge_prev_ff[0] & edge_now[0]));
		events[IRQ_EDGE_B_BIT]  = edge_cfg_ff[EDGE_B_EN_BIT] & (edge_cfg_ff[EDGE_B_FALL_BIT] ?
			(edge_prev_ff[1] & ~edge_now[1]) : (~edge_prev_ff[1] & edge_now[1]));
		events[IRQ_SHORT_A_BIT] = short_rise[0];
		events[IRQ_SHORT_B_BIT] = short_rise[1];
		nxt_edge_prev = edge_now;
		nxt_out_state = out_state_ff;
		nxt_edge_cfg  = edge_cfg_ff;
		nxt_irq_mask  = irq_mask_ff;
		nxt_irq_stat  = irq_stat_ff;
		hit           = 1'b1;
		case (paddr)
			OUT_STATE_OFFSET, IN_STATE_OFFSET, EDGE_CFG_OFFSET,
			IRQ_STAT_OFFSET, IRQ_MASK_OFFSET, PORT_STAT_OFFSET: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		if (wr_en)
		begin
			case (paddr)
				OUT_STATE_OFFSET: nxt_out_state = pwdata[15:0];
				EDGE_CFG_OFFSET:  nxt_edge_cfg  = pwdata[3:0];
				IRQ_MASK_OFFSET:  nxt_irq_mask  = pwdata[3:0];
				IRQ_STAT_OFFSET:  nxt_irq_stat  = irq_stat_ff & ~pwdata[3:0];
				default: ;
			endcase
		end
		nxt_irq_stat = nxt_irq_stat | events;  // Set wins over clear
		nxt_prdata = 32'h0;
		if (rd_en)
		begin
			case (paddr)
				OUT_STATE_OFFSET: nxt_prdata = {16'h0000, out_state_ff};
				IN_STATE_OFFSET:  nxt_prdata = {16'h0000, in_ff};
				EDGE_CFG_OFFSET:  nxt_prdata = {28'h0, edge_cfg_ff};
				IRQ_STAT_OFFSET:  nxt_prdata = {28'h0, irq_stat_ff};
				IRQ_MASK_OFFSET:  nxt_prdata = {28'h0, irq_mask_ff};
				PORT_STAT_OFFSET: nxt_prdata = {29'h0, sl_ff, hold_ff};
				default:          nxt_prdata = 32'h0;
			endcase
		end
		else if (psel & penable & ~pready)
			nxt_prdata = prdata;
		nxt_pready  = psel & ~penable;
		nxt_pslverr = psel & ~penable & ~hit;
		nxt_irq     = |(nxt_irq_stat & nxt_irq_mask);
		// Per group: program state unless held off; scan loss kills all
		for (int i = 0; i < IO_WIDTH; i++)
			nxt_switched_out[i] = out_state_ff[i] & ~hold_ff[i / GROUP_WIDTH] & ~sl_ff;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_state_ff <= OUT_STATE_RESET;
			edge_cfg_ff  <= EDGE_CFG_RESET;
			irq_mask_ff  <= IRQ_MASK_RESET;
			irq_stat_ff  <= 4'h0;
			edge_prev_ff <= 2'h0;
			switched_out <= 16'h0000;
			prdata       <= 32'h0;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			irq          <= 1'b0;
		end
		else
		begin
			out_state_ff <= nxt_out_state;
			edge_cfg_ff  <= nxt_edge_cfg;
			irq_mask_ff  <= nxt_irq_mask;
			irq_stat_ff  <= nxt_irq_stat;
			edge_prev_ff <= nxt_edge_prev;
			switched_out <= nxt_switched_out;
			prdata       <= nxt_prdata;
			pready       <= nxt_pready;
			pslverr      <= nxt_pslverr;
			irq          <= nxt_irq;
		end
	end

endmodule
`default_nettype wire

// ==== tb/field_io_monitor.sv ====
// Checker: output safety and bus timing of the field port
`default_nettype none
module field_io_monitor
	import field_io_pkg::*;
#(
	parameter int HOLD_CYCLES = 20
)(
	input wire logic        pclk,          // System clock
	input wire logic        presetn,       // Reset, active low
	input wire logic        psel,          // APB select
	input wire logic        penable,       // APB enable
	input wire logic        pwrite,        // APB write
	input wire logic [11:0] paddr,         // APB address
	input wire logic [31:0] pwdata,        // APB write data
	input wire logic [31:0] prdata,        // APB read data
	input wire logic        pready,        // APB ready
	input wire logic        pslverr,       // APB error
	input wire logic [15:0] field_in,      // Field inputs
	input wire logic [1:0]  short_sense,   // Group short sense
	input wire logic        scan_loss,     // Scan loss
	input wire logic [15:0] switched_out,  // Switched outputs
	input wire logic        irq            // Level interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	scan_off_a:
	assert property (scan_loss [*7] |-> switched_out == 16'h0000) else $error("output on in scan loss");
	scan_rise_a:
	assert property ($rose(scan_loss) |-> ##[1:7] switched_out == 16'h0000) else $error("scan loss too slow");
	short_grp_a_a:
	assert property ($rose(short_sense[0]) ##1 short_sense[0] [*3] |-> ##[0:6] (switched_out[7:0] == 8'h00) [*4])
		else $error("group A not held off");
	short_grp_b_a:
	assert property ($rose(short_sense[1]) ##1 short_sense[1] [*3] |-> ##[0:6] (switched_out[15:8] == 8'h00) [*4])
		else $error("group B not held off");
	irq_pending_a:
	assert property (irq && !$past(psel && pwrite) && !(psel && pwrite) |=> irq) else $error("irq dropped alone");
	ready_slot_a:
	assert property (psel && !penable |=> pready) else $error("no ready in access");
	ready_pulse_a:
	assert property (pready |=> !pready) else $error("ready too long");
endmodule
`default_nettype wire

// ==== tb/field_side_model.sv ====
// Field side model: shorted loads and input devices
`default_nettype none
module field_side_model (
	input  wire logic [15:0] switched_out, // Outputs of the port
	input  wire logic [15:0] shorted_load, // Loads wired as a short
	input  wire logic [15:0] device_level, // Input device states
	output logic      [15:0] field_in,     // Input lines to the port
	output logic      [1:0]  short_sense   // Group short sense
);
	timeunit 1ns;
	timeprecision 1ps;
	// A short draws current only while its switch conducts
	assign short_sense[0] = |(switched_out[7:0] & shorted_load[7:0]);
	assign short_sense[1] = |(switched_out[15:8] & shorted_load[15:8]);
	assign field_in = device_level;
endmodule
`default_nettype wire

// ==== tb/grouped_field_io_port_test.sv ====
// Testbench: outputs, inputs, edge interrupts, short hold-off and scan loss
`default_nettype none
module grouped_field_io_port_test import field_io_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HC = 20;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, scan_loss = 1'b0;
	logic pready, pslverr, irq, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [15:0] switched_out, field_in, shorted = 16'h0000, dev = 16'h0000;
	logic [1:0] short_sense;
	int n_mismatch = 0, checked = 0;
	always #5 pclk = ~pclk;
	grouped_field_io_port #(.HOLD_CYCLES(HC)) i_grouped_field_io_port (
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.field_in     (field_in),
		.short_sense  (short_sense),
		.scan_loss    (scan_loss),
		.switched_out (switched_out),
		.irq          (irq)
	);
	field_side_model i_field_side_model (.switched_out, .shorted_load(shorted), .device_level(dev), .field_in,
		.short_sense);
	task automatic chk(input string n, input logic [31:0] e, s);
		checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, e, q);
	endtask
	task automatic t_io;
		apb(1'b1, OUT_STATE_OFFSET, 32'h0000a55a);
		dev <= 16'h8001;
		repeat (8) @(posedge pclk);
		chk("outputs", 32'h0000a55a, {16'h0000, switched_out});
		rd(OUT_STATE_OFFSET, 32'h0000a55a, "out_state");
		rd(IN_STATE_OFFSET, 32'h00008001, "inputs");
		rd(12'h0fc, 32'h0, "unmapped");
		chk("slverr", 32'h1, {31'h0, err});
		$display("io test done");
	endtask
	task automatic edge_case(input logic [3:0] m, cfg, input logic [15:0] lv, input logic [1:0] e);
		apb(1'b1, IRQ_MASK_OFFSET, {28'h0, m});
		apb(1'b1, EDGE_CFG_OFFSET, {28'h0, cfg});
		rd(IRQ_MASK_OFFSET, {28'h0, m}, "irq_mask");
		rd(EDGE_CFG_OFFSET, {28'h0, cfg}, "edge_cfg");
		dev <= lv;
		repeat (10) @(posedge pclk);
		chk("irq", {31'h0, |(e & m[1:0])}, {31'h0, irq});
		rd(IRQ_STAT_OFFSET, {30'h0, e}, "edge_flags");
		apb(1'b1, IRQ_STAT_OFFSET, 32'h0000000f);
		repeat (2) @(posedge pclk);
		chk("irq_clear", 32'h0, {31'h0, irq});
		$display("edge test done");
	endtask
	task automatic t_short(input logic g);
		shorted <= g ? 16'h0100 : 16'h0002;
		repeat (12) @(posedge pclk);
		shorted <= 16'h0000;
		chk("group_off", g ? 32'h005a : 32'ha500, {16'h0000, switched_out});
		rd(PORT_STAT_OFFSET, g ? 32'h2 : 32'h1, "hold_bit");
		repeat (HC / 2) @(posedge pclk);
		chk("still_off", g ? 32'h005a : 32'ha500, {16'h0000, switched_out});
		repeat (HC + 15) @(posedge pclk);
		chk("restored", 32'ha55a, {16'h0000, switched_out});
		rd(IRQ_STAT_OFFSET, g ? 32'h8 : 32'h4, "short_flag");
		apb(1'b1, IRQ_STAT_OFFSET, 32'h0000000f);
		scan_loss <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("scan_off", 32'h0, {16'h0000, switched_out});
		rd(PORT_STAT_OFFSET, 32'h4, "scan_bit");
		scan_loss <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("scan_back", 32'ha55a, {16'h0000, switched_out});
		$display("short test done");
	endtask
	task automatic wrap_up;
		$display("checked %0d mismatched %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		t_io;
		edge_case(4'h3, 4'h5, 16'h0101, 2'b10);
		edge_case(4'h3, 4'hf, 16'h0000, 2'b11);
		edge_case(4'h3, 4'h5, 16'h0001, 2'b01);
		edge_case(4'h3, 4'h0, 16'h0100, 2'b00);
		edge_case(4'h0, 4'h5, 16'h0101, 2'b01);
		t_short(1'b0);
		t_short(1'b1);
		wrap_up;
	end
	initial
	begin
		#20000;
		n_mismatch++;
		wrap_up;
	end
endmodule
bind grouped_field_io_port field_io_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) i_field_io_monitor (
	.pclk         (pclk),
	.presetn      (presetn),
	.psel         (psel),
	.penable      (penable),
	.pwrite       (pwrite),
	.paddr        (paddr),
	.pwdata       (pwdata),
	.prdata       (prdata),
	.pready       (pready),
	.pslverr      (pslverr),
	.field_in     (field_in),
	.short_sense  (short_sense),
	.scan_loss    (scan_loss),
	.switched_out (switched_out),
	.irq          (irq)
);
`default_nettype wire
